// [hw/gpib_listener_command_front.sv]
`timescale 1ns/1ps
`include "gpib_cfg.svh"
// Behaviour
// RULE1 - attention aborts current transfer immediately, dropping its state
// RULE2 - power-up clears talk, listen, srq, status, buffer; local; partial init
// RULE3 - interface clear drops only talker and listener flags; code also aborts the current transfer as for attention
// RULE4 - device clear drops talker, srq, status, buffer; partial init; keeps remote
// RULE5 - trigger clears status trigger bit, talker and buffer; keeps srq
// RULE6 - reset codes: talk off, listen on, remote, clear srq/status/buffer, init
// RULE7 - talk address sets talk; listen address sets listen; poll clears listen, srq
// RULE8 - address of 31 or more on enter is refused, error shown, old kept
// RULE9 - setting selects addressable or listen-only reception
// RULE10 - no controller may share the bus in listen-only mode
// RULE11 - setting selects header or no header on talker data
// RULE12 - setting selects native or compatibility code dialect
// RULE13 - edits take effect on enter; cancel restores previous settings
// RULE14 - controller sends ascii codes, commas optional between codes
// RULE15 - block ends on eoi, alone or with cr lf, lf, or cr
// RULE16 - up to 400 code characters per block, terminator excluded
// RULE17 - over-length block or unknown code raises syntax error
// RULE18 - after syntax error, codes up to terminator are discarded
// RULE19 - bus address selectable over 31 values from local panel
// RULE20 - syntax error raises error event visible in status
module gpib_listener_command_front
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic talkFlag,
   output logic listenFlag,
   output logic remoteFlag,
   output logic srqFlag,
   output logic headerEnable,
   output logic dialectCompat,
   output logic [1:0] initPulse,
   output logic xmitClear
);
   import gpib_pkg::*;
   logic [7:0] ifsetReg;
   logic [7:0] editReg;
   logic [7:0] stbReg;
   logic talk_reg, listen_reg, remote_reg, srq_reg;
   logic addrErr_reg;
   logic synErrSticky_reg;
   logic blkSticky_reg;
   logic [1:0] init_reg;
   logic xclr_reg;
   logic [7:0] awAddr_reg;
   logic awHeld_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic wHeld_reg;
   logic rxValid_reg, rxEoi_reg, rxBad_reg;
   logic [7:0] rxData_reg;
   logic synErr, blockDone, discarding, doWrite;
   logic [15:0] charCount;
   logic [15:0] act;
   logic actPower, actIfc, actDcl, actGet, actPrst, actFrst, actMta, actMla;
   logic actUnt, actUnl, actPoll, actEnter, actCancel, actOper, actAtn;
   logic clrTalk, clrSrq, clrStb, addrBad, listenOnly, rdHit, wrHit;
   logic [31:0] statusWord, readWord, editMerged;

   function automatic logic [31:0] mergeStrb(input logic [31:0] oldV, input logic [31:0] newV,
      input logic [3:0] strb);
      logic [31:0] r;
      r = oldV;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            r[i*8 +: 8] = newV[i*8 +: 8];
      return r;
   endfunction

   // axi write channel capture, either order
   assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
   assign wrHit = (awAddr_reg == `OFF_CTRL) || (awAddr_reg == `OFF_IFSET)
      || (awAddr_reg == `OFF_EDIT) || (awAddr_reg == `OFF_CODE)
      || (awAddr_reg == `OFF_RXCHAR) || (awAddr_reg == `OFF_ACT)
      || (awAddr_reg == `OFF_STAT);
   assign act = (doWrite && awAddr_reg == `OFF_ACT) ? wData_reg[15:0] : 16'h0000;
   assign actPower = act[`A_POWER];
   assign actIfc = act[`A_IFC];
   assign actDcl = act[`A_DCL];
   assign actGet = act[`A_GET];
   assign actPrst = act[`A_PRST];
   assign actFrst = act[`A_FRST];
   assign actMta = act[`A_MTA] && !listenOnly;
   assign actMla = act[`A_MLA] && !listenOnly;
   assign actUnt = act[`A_UNT];
   assign actUnl = act[`A_UNL];
   assign actPoll = act[`A_SPOLL];
   assign actEnter = act[`A_ENTER];
   assign actCancel = act[`A_CANCEL];
   assign actOper = act[`A_OPER];
   assign actAtn = act[`A_ATN] || actIfc; // RULE1
   assign listenOnly = ifsetReg[`F_LONLY]; // RULE9
   assign addrBad = editReg[`F_ADDR_LSB +: 5] >= `ADDR_LIMIT; // RULE8 RULE19
   assign editMerged = mergeStrb({24'h000000, editReg}, wData_reg, wStrb_reg);
   assign clrTalk = actPower || actIfc || actDcl || actGet || actPrst || actFrst
      || actOper || actUnt || actMla;
   assign clrSrq = actPower || actDcl || actPrst || actFrst || actPoll;
   assign clrStb = actPower || actDcl || actPrst || actFrst;
   assign statusWord = {8'h00, stbReg, 5'b00000, blkSticky_reg, 1'b0, init_reg[1], 2'b00,
      synErrSticky_reg, addrErr_reg, srq_reg, remote_reg, listen_reg, talk_reg};
   assign rdHit = (s_axi_araddr == `OFF_CTRL) || (s_axi_araddr == `OFF_STAT)
      || (s_axi_araddr == `OFF_IFSET) || (s_axi_araddr == `OFF_EDIT)
      || (s_axi_araddr == `OFF_CODE) || (s_axi_araddr == `OFF_RXCHAR)
      || (s_axi_araddr == `OFF_ACT);
   assign readWord = (s_axi_araddr == `OFF_STAT) ? (statusWord | {15'h0000, discarding,
      16'h0000}) :
      (s_axi_araddr == `OFF_IFSET) ? {24'h000000, ifsetReg} :
      (s_axi_araddr == `OFF_EDIT) ? {24'h000000, editReg} :
      (s_axi_araddr == `OFF_CODE) ? {16'h0000, charCount} :
      32'h00000000;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h00000000;
         wStrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end
      else if (ce)
      begin
         s_axi_awready <= !awHeld_reg && !s_axi_awready;
         s_axi_wready <= !wHeld_reg && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? 2'b00 : 2'b10;
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end
      else if (ce)
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readWord;
            s_axi_rresp <= rdHit ? 2'b00 : 2'b10;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // settings edit and commit
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ifsetReg <= `IFSET_RST;
         editReg <= `IFSET_RST;
         addrErr_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (doWrite && awAddr_reg == `OFF_EDIT)
            editReg <= editMerged[7:0];
         else if (actEnter && addrBad)
         begin
            editReg <= ifsetReg; // RULE8
            addrErr_reg <= 1'b1; // RULE8
         end
         else if (actEnter)
         begin
            ifsetReg <= editReg; // RULE13
            addrErr_reg <= 1'b0;
         end
         else if (actCancel)
            editReg <= ifsetReg; // RULE13
         if (doWrite && awAddr_reg == `OFF_STAT && wData_reg[`S_ADDRERR] && !(actEnter && addrBad))
            addrErr_reg <= 1'b0;
      end
   end

   // interface state flags
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         talk_reg <= 1'b0; // RULE2
         listen_reg <= 1'b0;
         remote_reg <= 1'b0;
         srq_reg <= 1'b0;
         stbReg <= 8'h00;
         init_reg <= INIT_PARTIAL;
         xclr_reg <= 1'b1;
      end
      else if (ce)
      begin
         init_reg <= actFrst ? INIT_FULL : // RULE6
            (actPower || actDcl || actPrst) ? INIT_PARTIAL : INIT_NONE; // RULE2 RULE4
         xclr_reg <= actPower || actDcl || actGet || actPrst || actFrst; // RULE4 RULE5
         if (actMta)
            talk_reg <= 1'b1; // RULE7
         else if (clrTalk)
            talk_reg <= 1'b0; // RULE3 RULE4 RULE5
         if (actPower || actIfc || actUnl || actPoll || actMta)
            listen_reg <= 1'b0; // RULE3 RULE7
         else if (actMla || actPrst || actFrst || actOper)
            listen_reg <= 1'b1; // RULE6 RULE7
         if (actPower)
            remote_reg <= 1'b0; // RULE2
         else if (actPrst || actFrst || actOper)
            remote_reg <= 1'b1; // RULE6
         if (synErr)
            srq_reg <= 1'b1; // RULE20
         else if (clrSrq)
            srq_reg <= 1'b0; // RULE4 RULE7
         if (synErr)
            stbReg[`STB_TRIG_BIT] <= 1'b1;
         else if (clrStb)
            stbReg <= 8'h00; // RULE4 RULE6
         else if (actGet)
            stbReg[`STB_TRIG_BIT] <= 1'b0; // RULE5
      end
   end

   // receive character capture
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rxValid_reg <= 1'b0;
         rxData_reg <= 8'h00;
         rxEoi_reg <= 1'b0;
         rxBad_reg <= 1'b0;
         synErrSticky_reg <= 1'b0;
         blkSticky_reg <= 1'b0;
      end
      else if (ce)
      begin
         rxValid_reg <= doWrite && awAddr_reg == `OFF_RXCHAR && (listenOnly || listen_reg);
         rxData_reg <= wData_reg[7:0];
         rxEoi_reg <= wData_reg[8];
         rxBad_reg <= wData_reg[9];
         if (synErr)
            synErrSticky_reg <= 1'b1; // RULE20
         else if (doWrite && awAddr_reg == `OFF_STAT && wData_reg[`S_SYNERR])
            synErrSticky_reg <= 1'b0;
         if (blockDone)
            blkSticky_reg <= 1'b1;
         else if (doWrite && awAddr_reg == `OFF_STAT && wData_reg[`S_BLKDONE])
            blkSticky_reg <= 1'b0;
      end
   end

   block_parser parser
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .abort(actAtn),
      .charValid(rxValid_reg),
      .charData(rxData_reg),
      .charEoi(rxEoi_reg),
      .codeBad(rxBad_reg),
      .synErr(synErr),
      .blockDone(blockDone),
      .discarding(discarding),
      .charCount(charCount)
   );

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         talkFlag <= 1'b0;
         listenFlag <= 1'b0;
         remoteFlag <= 1'b0;
         srqFlag <= 1'b0;
         headerEnable <= 1'b0;
         dialectCompat <= 1'b0;
         initPulse <= 2'b00;
         xmitClear <= 1'b0;
      end
      else if (ce)
      begin
         talkFlag <= talk_reg;
         listenFlag <= listen_reg;
         remoteFlag <= remote_reg;
         srqFlag <= srq_reg;
         headerEnable <= ifsetReg[`F_HDR]; // RULE11
         dialectCompat <= ifsetReg[`F_DIAL]; // RULE12
         initPulse <= init_reg;
         xmitClear <= xclr_reg;
      end
   end

   chk_ifc_keeps_remote: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
      (ce && actIfc && !actPower && !actPrst && !actFrst && !actOper)
      |=> (!talk_reg && !listen_reg && remote_reg == $past(remote_reg)))
      else $error("interface clear changed remote");
   chk_dcl_clears: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
      (ce && actDcl && !synErr && !actMta) |=> (!talk_reg && !srq_reg && stbReg == 8'h00
      && xclr_reg && init_reg == INIT_PARTIAL))
      else $error("device clear incomplete");
   chk_reset_code: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
      (ce && actFrst && !actPower && !actIfc && !actUnl && !actPoll && !actMta && !synErr)
      |=> (listen_reg && remote_reg && !talk_reg && init_reg == INIT_FULL))
      else $error("full reset code wrong");
   chk_bad_addr: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
      (ce && actEnter && addrBad) |=> (addrErr_reg && ifsetReg == $past(ifsetReg)))
      else $error("bad address accepted");
   chk_cancel_edit: assert property (@(posedge clk_sys) disable iff (rst) // RULE13
      (ce && actCancel && !actEnter) |=> (editReg == ifsetReg && ifsetReg == $past(ifsetReg)))
      else $error("cancel did not restore");
   chk_talk_addr: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
      (ce && actMta) |=> ##1 (talkFlag && !listenFlag))
      else $error("talk address wrong");
endmodule

// [hw/gpib_cfg.svh]
`ifndef GPIB_CFG_SVH
`define GPIB_CFG_SVH
// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define OFF_IFSET 8'h08
`define OFF_EDIT 8'h0C
`define OFF_CODE 8'h10
`define OFF_RXCHAR 8'h14
`define OFF_ACT 8'h18
// edit/interface setting fields
`define F_ADDR_LSB 0
`define F_LONLY 5
`define F_HDR 6
`define F_DIAL 7
`define IFSET_RST 8'h00
// status fields
`define S_TALK 0
`define S_LSN 1
`define S_RMT 2
`define S_SRQ 3
`define S_ADDRERR 4
`define S_SYNERR 5
`define S_DISCARD 6
`define S_INIT_LSB 8
`define S_BLKDONE 10
// action command bits (write pulses)
`define A_POWER 0
`define A_IFC 1
`define A_DCL 2
`define A_GET 3
`define A_PRST 4
`define A_FRST 5
`define A_MTA 6
`define A_MLA 7
`define A_UNT 8
`define A_UNL 9
`define A_SPOLL 10
`define A_ENTER 11
`define A_CANCEL 12
`define A_OPER 13
`define A_ATN 14
`define A_BADCODE 15
// stream
`define MAX_CHARS 16'd400
`define ADDR_LIMIT 5'd31
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define STB_TRIG_BIT 2
`endif

// [hw/gpib_pkg.sv]
package gpib_pkg;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_RECV = 2'b01,
      RX_DISCARD = 2'b10
   } rx_state_t;
   typedef enum logic [1:0] {
      INIT_NONE = 2'b00,
      INIT_PARTIAL = 2'b01,
      INIT_FULL = 2'b10
   } init_kind_t;
endpackage

// [hw/block_parser.sv]
`timescale 1ns/1ps
`include "gpib_cfg.svh"
module block_parser
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic abort,
   input wire logic charValid,
   input wire logic [7:0] charData,
   input wire logic charEoi,
   input wire logic codeBad,
   output logic synErr,
   output logic blockDone,
   output logic discarding,
   output logic [15:0] charCount
);
   import gpib_pkg::*;
   rx_state_t stateReg;
   rx_state_t stateNext;
   logic [15:0] countReg;
   logic isDelim;
   logic isBody;
   logic overLimit;
   logic errNow;
   assign isDelim = (charData == `CH_CR) || (charData == `CH_LF);
   assign isBody = charValid && !isDelim;
   assign overLimit = isBody && (countReg >= `MAX_CHARS); // RULE16
   assign errNow = (stateReg != RX_DISCARD) && isBody && (overLimit || codeBad); // RULE17
   always_comb
   begin
      stateNext = stateReg;
      case (stateReg)
         RX_IDLE, RX_RECV:
         begin
            if (charValid && charEoi)
               stateNext = RX_IDLE; // RULE15
            else if (errNow)
               stateNext = RX_DISCARD; // RULE18
            else if (isBody)
               stateNext = RX_RECV;
         end
         RX_DISCARD:
         begin
            if (charValid && charEoi)
               stateNext = RX_IDLE; // RULE18
         end
         default:
            stateNext = RX_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         stateReg <= RX_IDLE;
         countReg <= 16'h0000;
         synErr <= 1'b0;
         blockDone <= 1'b0;
      end
      else if (ce)
      begin
         if (abort)
         begin
            stateReg <= RX_IDLE; // RULE1
            countReg <= 16'h0000;
            synErr <= 1'b0;
            blockDone <= 1'b0;
         end
         else
         begin
            stateReg <= stateNext;
            synErr <= errNow && !(charValid && charEoi && !isBody);
            blockDone <= charValid && charEoi; // RULE15
            if (charValid && charEoi)
               countReg <= 16'h0000;
            else if (isBody && stateReg != RX_DISCARD && countReg < `MAX_CHARS + 16'd1) // RULE18
               countReg <= countReg + 16'd1;
         end
      end
   end
   assign discarding = (stateReg == RX_DISCARD);
   assign charCount = countReg;
   chk_limit_error: assert property (@(posedge clk_sys) disable iff (rst) // RULE16
      (ce && !abort && stateReg == RX_RECV && isBody && countReg == `MAX_CHARS
      && !charEoi) |=> (stateReg == RX_DISCARD))
      else $error("over-length block not discarded");
   chk_discard_hold: assert property (@(posedge clk_sys) disable iff (rst) // RULE18
      (ce && !abort && stateReg == RX_DISCARD && !(charValid && charEoi))
      |=> (stateReg == RX_DISCARD))
      else $error("discard ended before terminator");
endmodule

// [sim/bus_controller_model.sv]
`timescale 1ns/1ps
module bus_controller_model
(
   input wire logic clk_sys,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready,
   output logic hung
);
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
   end
   // released address and data lines show the inverse of what they carried
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic awDone;
      logic wDone;
      n = 0;
      awDone = 1'b0;
      wDone = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(awDone && wDone) && n < 200)
      begin
         @(posedge clk_sys);
         n++;
         if (!awDone && s_axi_awready === 1'b1)
         begin
            awDone = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (!wDone && s_axi_wready === 1'b1)
         begin
            wDone = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end
      do
      begin
         @(posedge clk_sys);
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 200);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 200)
         hung <= 1'b1;
   endtask
   task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 200);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      while (s_axi_rvalid !== 1'b1 && n < 200)
      begin
         @(posedge clk_sys);
         n++;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 200)
         hung <= 1'b1;
   endtask
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
`include "gpib_cfg.svh"
module testbench;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, cnt;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp, initPulse;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hung;
   logic talkFlag, listenFlag, remoteFlag, srqFlag, headerEnable, dialectCompat, xmitClear;
   logic sawPartial = 1'b0;
   logic sawFull = 1'b0;
   logic sawClr = 1'b0;
   int num_errors = 0;
   int n_tests = 0;
   always #12.5 clk_sys = ~clk_sys;
   gpib_listener_command_front i_gpib_listener_command_front (.*);
   bus_controller_model i_bus_controller_model (.*);
   // pulse catcher for init and buffer clear
   always @(posedge clk_sys)
   begin
      if (initPulse === 2'b01)
         sawPartial = 1'b1;
      if (initPulse === 2'b10)
         sawFull = 1'b1;
      if (xmitClear === 1'b1)
         sawClr = 1'b1;
      if (hung === 1'b1)
      begin
         num_errors++;
         results();
      end
   end
   task automatic results();
      $display("errors %0d of %0d checks", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_bus_controller_model.axiWrite(a, d, resp);
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic rdr(input logic [7:0] a);
      i_bus_controller_model.axiRead(a, rd, resp);
   endtask
   task automatic act(input int b);
      sawPartial = 1'b0;
      sawFull = 1'b0;
      sawClr = 1'b0;
      wr(`OFF_ACT, 32'h1 << b);
   endtask
   task automatic flags(input logic [3:0] e);
      chk({28'h0, srqFlag, remoteFlag, listenFlag, talkFlag}, {28'h0, e});
   endtask
   // ascii codes, commas optional between codes
   task automatic ch(input logic [7:0] c, input logic eoi, input logic bad);
      wr(`OFF_RXCHAR, {22'h0, bad, eoi, c});
   endtask
   task automatic synErr();
      ch(8'h51, 1'b0, 1'b1);
      ch(`CH_LF, 1'b1, 1'b0);
   endtask
   initial
   begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      ce <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk(32'({sawPartial, sawClr, initPulse}), 32'h0);
      ce <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk(32'({sawPartial, sawClr}), 32'h3);
      flags(4'h0);
      rdr(`OFF_STAT);
      chk(rd, 32'h0);
      rdr(`OFF_IFSET);
      chk(rd, 32'(`IFSET_RST));
      rdr(`OFF_CTRL);
      chk(rd, 32'h0);
      chk(32'(resp), 32'h0);
      rdr(8'h1C);
      chk(rd, 32'h0);
      chk(32'(resp), 32'h2);
      i_bus_controller_model.axiWrite(8'h1C, 32'h1, resp);
      chk(32'(resp), 32'h2);
      // address 30, header and compatibility dialect
      wr(`OFF_EDIT, 32'hDE);
      act(`A_ENTER);
      rdr(`OFF_IFSET);
      chk(rd, 32'hDE);
      chk(32'({headerEnable, dialectCompat}), 32'h3);
      wr(`OFF_EDIT, 32'h05);
      act(`A_CANCEL);
      rdr(`OFF_IFSET);
      chk(rd, 32'hDE);
      rdr(`OFF_EDIT);
      chk(rd, 32'hDE);
      wr(`OFF_EDIT, 32'h1F);
      act(`A_ENTER);
      rdr(`OFF_IFSET);
      chk(rd, 32'hDE);
      rdr(`OFF_EDIT);
      chk(rd, 32'hDE);
      rdr(`OFF_STAT);
      chk(32'(rd[`S_ADDRERR]), 32'h1);
      wr(`OFF_STAT, 32'h1 << `S_ADDRERR);
      wr(`OFF_EDIT, 32'h00);
      act(`A_ENTER);
      chk(32'({headerEnable, dialectCompat}), 32'h0);
      ch(8'h41, 1'b0, 1'b0);
      rdr(`OFF_CODE);
      chk(rd, 32'h0);
      // listen-only: no addressing commands are sent meanwhile
      wr(`OFF_EDIT, 32'h20);
      act(`A_ENTER);
      ch(8'h41, 1'b0, 1'b0);
      ch(8'h42, 1'b0, 1'b0);
      rdr(`OFF_CODE);
      chk(rd, 32'h2);
      ch(`CH_LF, 1'b1, 1'b0);
      wr(`OFF_EDIT, 32'h00);
      act(`A_ENTER);
      act(`A_MLA);
      flags(4'h2);
      // the four block terminator forms
      for (int k = 0; k < 4; k++)
      begin
         wr(`OFF_STAT, 32'h1 << `S_BLKDONE);
         ch(8'h56, 1'b0, 1'b0);
         ch(8'h34, 1'b0, 1'b0);
         ch(8'h2C, 1'b0, 1'b0);
         rdr(`OFF_CODE);
         chk(rd, 32'h3);
         case (k)
            0:
            begin
               ch(`CH_CR, 1'b0, 1'b0);
               ch(`CH_LF, 1'b1, 1'b0);
            end
            1: ch(`CH_LF, 1'b1, 1'b0);
            2: ch(`CH_CR, 1'b1, 1'b0);
            default: ch(8'h47, 1'b1, 1'b0);
         endcase
         rdr(`OFF_STAT);
         chk(32'({rd[`S_BLKDONE], rd[`S_SYNERR]}), 32'h2);
      end
      for (int i = 0; i < 400; i++)
         ch(8'h41, 1'b0, 1'b0);
      rdr(`OFF_STAT);
      chk(32'(rd[`S_SYNERR]), 32'h0);
      rdr(`OFF_CODE);
      chk(rd, 32'd400);
      ch(8'h41, 1'b0, 1'b0);
      rdr(`OFF_STAT);
      chk(32'({rd[`S_SYNERR], rd[16], rd[18]}), 32'h7);
      chk(32'(srqFlag), 32'h1);
      rdr(`OFF_CODE);
      cnt = rd;
      ch(8'h42, 1'b0, 1'b0);
      rdr(`OFF_CODE);
      chk(rd, cnt);
      ch(`CH_LF, 1'b1, 1'b0);
      rdr(`OFF_STAT);
      chk(32'(rd[16]), 32'h0);
      wr(`OFF_STAT, 32'h1 << `S_SYNERR);
      ch(8'h56, 1'b0, 1'b0);
      ch(8'h51, 1'b0, 1'b1);
      rdr(`OFF_STAT);
      chk(32'(rd[`S_SYNERR]), 32'h1);
      rdr(`OFF_CODE);
      cnt = rd;
      ch(8'h34, 1'b0, 1'b0);
      rdr(`OFF_CODE);
      chk(rd, cnt);
      ch(`CH_LF, 1'b1, 1'b0);
      act(`A_FRST);
      flags(4'h6);
      chk(32'({sawFull, sawClr}), 32'h3);
      rdr(`OFF_STAT);
      chk(32'(rd[23:16]), 32'h0);
      synErr();
      act(`A_MTA);
      flags(4'hD);
      act(`A_IFC);
      flags(4'hC);
      rdr(`OFF_STAT);
      chk(32'(rd[18]), 32'h1);
      act(`A_MTA);
      act(`A_GET);
      chk(32'({srqFlag, talkFlag, sawClr}), 32'h5);
      rdr(`OFF_STAT);
      chk(32'(rd[18]), 32'h0);
      act(`A_MLA);
      synErr();
      act(`A_MTA);
      act(`A_DCL);
      flags(4'h4);
      chk(32'({sawPartial, sawClr}), 32'h3);
      rdr(`OFF_STAT);
      chk(32'(rd[23:16]), 32'h0);
      act(`A_MLA);
      synErr();
      act(`A_SPOLL);
      flags(4'h4);
      act(`A_MTA);
      act(`A_UNT);
      flags(4'h4);
      act(`A_MLA);
      act(`A_UNL);
      flags(4'h4);
      act(`A_MLA);
      act(`A_PRST);
      flags(4'h6);
      chk(32'({sawPartial, sawClr}), 32'h3);
      ch(8'h41, 1'b0, 1'b0);
      ch(8'h42, 1'b0, 1'b0);
      act(`A_ATN);
      act(`A_MLA);
      ch(8'h43, 1'b0, 1'b0);
      rdr(`OFF_CODE);
      chk(rd, 32'h1);
      act(`A_POWER);
      flags(4'h0);
      chk(32'({sawPartial, sawClr}), 32'h3);
      act(`A_MTA);
      act(`A_OPER);
      flags(4'h6);
      results();
   end
endmodule
